/* shared/spindle_regs.vh */
// Register map, field layouts, reset values, range limits and scale constants of the spindle logic
// Functional notes
// - Orientation request enables position loop and drives motor toward stored target.
// - Orientation runs at set speed 5..1000 r/min, default 100, then stops on target.
// - Orientation-complete asserts when residual error lies inside tolerance window.
// - Tolerance window 0..100 counts, default 2; tiny windows may chatter.
// - Position counts four per encoder line.
// - Two select inputs pick one of four targets: 00->1, 01->2, 10->3, 11->4.
// - With selects unassigned by default only target 1 is used.
// - After power-on the position is flagged unreferenced and invalid.
// - Position becomes referenced only after an index pulse is seen.
// - Speed arrival asserts when speed lies within command times (100 +/- range)%.
// - Speed arrival range 1..100 percent, default 10.
// - Arrival window works symmetrically for negative commands too.
// - Full-scale analog command maps to 0..15500 r/min, default 6000.
// - Signed zero-drift offset -1000..1000, default 0, adds to the analog command.
// - Zero-speed clamp stops and locks the motor with a nonzero command.
// - Clamp input with nonzero command in speed mode locks the motor.
`ifndef SPINDLE_REGS_VH
`define SPINDLE_REGS_VH

`define REG_CTRL        12'h000
`define REG_ORSPEED     12'h004
`define REG_ORTOL       12'h008
`define REG_TGT1        12'h00c
`define REG_TGT2        12'h010
`define REG_TGT3        12'h014
`define REG_TGT4        12'h018
`define REG_ARRPCT      12'h01c
`define REG_FULLSCALE   12'h020
`define REG_ZOFFSET     12'h024
`define REG_STATUS      12'h028
`define REG_POSITION    12'h02c
`define REG_SPEED       12'h030

`define CTRL_SELEN_BIT  0
`define CTRL_SPDMODE_BIT 1

`define RST_CTRL        32'h0000_0002
`define RST_ORSPEED     16'd100
`define RST_ORTOL       8'd2
`define RST_ARRPCT      8'd10
`define RST_FULLSCALE   16'd6000
`define RST_ZOFFSET     16'h0000

`define MIN_ORSPEED     16'd5
`define MAX_ORSPEED     16'd1000
`define MAX_ORTOL       8'd100
`define MIN_ARRPCT      8'd1
`define MAX_ARRPCT      8'd100
`define MAX_FULLSCALE   16'd15500
`define MIN_ZOFFSET     -1000
`define MAX_ZOFFSET     1000

`define COUNTS_PER_LINE 4
`define CMD_FULL_CODE   32767

`endif

/* rtl/quad_position.v */
// Quadrature decoder with index referencing
`timescale 1ns/1ps
`include "spindle_regs.vh"
module quad_position #(
  parameter POS_W = 24
) (
  input  wire             clock,
  input  wire             nrst,
  input  wire             encA,
  input  wire             encB,
  input  wire             encZ,
  input  wire [POS_W-1:0] countsPerRev,
  output reg  [POS_W-1:0] position_q,
  output reg              referenced_q,
  output reg  signed [15:0] stepSum_q
);
  reg [1:0] ab_q;
  reg       z_q;
  reg       inc;
  reg       dec;
  wire [1:0] abNow = {encA, encB};

  // Each AB edge is one count, four per line
  always @* begin
    inc = 1'b0;
    dec = 1'b0;
    case ({ab_q, abNow})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: inc = 1'b1;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: dec = 1'b1;
      default: begin
        inc = 1'b0;
        dec = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!nrst) begin
      ab_q         <= 2'b00;
      z_q          <= 1'b0;
      position_q   <= {POS_W{1'b0}};
      referenced_q <= 1'b0;
      stepSum_q    <= 16'sh0000;
    end else begin
      ab_q <= abNow;
      z_q  <= encZ;
      if (encZ && !z_q) begin
        position_q   <= {POS_W{1'b0}};
        referenced_q <= 1'b1;
      end else if (inc) begin
        position_q <= (position_q + 1'b1 >= countsPerRev) ? {POS_W{1'b0}} : position_q + 1'b1;
      end else if (dec) begin
        position_q <= (position_q == {POS_W{1'b0}}) ? countsPerRev - 1'b1 : position_q - 1'b1;
      end
      if (inc)
        stepSum_q <= stepSum_q + 16'sd1;
      else if (dec)
        stepSum_q <= stepSum_q - 16'sd1;
    end
  end
endmodule // quad_position

/* rtl/ahb_reg_slave.v */
// AHB-Lite slave front end: latches address phase, yields write strobes and read port
`timescale 1ns/1ps
module ahb_reg_slave (
  input  wire        clock,
  input  wire        nrst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg         hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  output reg         wrEn,
  output reg  [11:0] wrAddr,
  output reg  [31:0] wrData,
  output wire [11:0] rdAddr,
  input  wire [31:0] rdData
);
  reg        wrPend_q;
  reg [11:0] addr_q;
  wire       take = hsel && hready && htrans[1];

  assign hresp  = 1'b0;
  assign rdAddr = haddr[11:0];

  always @(posedge clock) begin
    if (!nrst) begin
      wrPend_q  <= 1'b0;
      addr_q    <= 12'h000;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      wrEn      <= 1'b0;
      wrAddr    <= 12'h000;
      wrData    <= 32'h0000_0000;
    end else begin
      wrEn <= wrPend_q;
      if (wrPend_q) begin
        wrAddr <= addr_q;
        wrData <= hwdata;
      end
      wrPend_q <= take && hwrite;
      if (take) begin
        addr_q <= haddr[11:0];
        if (!hwrite)
          hrdata <= rdData;
      end
    end
  end
endmodule // ahb_reg_slave

/* rtl/spindle_orientation_speed_arrival.v */
// Spindle orientation, speed arrival and analog command scaling core
`timescale 1ns/1ps
`include "spindle_regs.vh"
module spindle_orientation_speed_arrival #(
  parameter POS_W        = 24,
  parameter CMD_W        = 16,
  parameter COUNTS_REV   = 4096
) (
  input  wire                    clock,
  input  wire                    nrst,
  input  wire                    hsel,
  input  wire [31:0]             haddr,
  input  wire [1:0]              htrans,
  input  wire                    hwrite,
  input  wire [2:0]              hsize,
  input  wire                    hready,
  input  wire [31:0]             hwdata,
  output wire                    hreadyout,
  output wire                    hresp,
  output wire [31:0]             hrdata,
  input  wire                    servo_enable_in,
  input  wire                    forward_run_in,
  input  wire                    orient_request_in,
  input  wire [1:0]              orient_select_in,
  input  wire                    zero_clamp_in,
  input  wire signed [CMD_W-1:0] analog_speed_cmd,
  input  wire signed [15:0]      actualSpeed,
  input  wire                    encA,
  input  wire                    encB,
  input  wire                    encZ,
  output reg                     orient_done_out,
  output reg                     arrival_out,
  output reg                     posLoopEn,
  output reg                     motorLock,
  output reg  signed [15:0]      speedRef,
  output reg                     positionValid
);
  reg [31:0]        ctrl_q;
  reg [15:0]        orient_speed_param;
  reg [7:0]         orient_tolerance_param;
  reg [POS_W-1:0]   orient_target_one;
  reg [POS_W-1:0]   orient_target_two;
  reg [POS_W-1:0]   orient_target_three;
  reg [POS_W-1:0]   orient_target_four;
  reg [7:0]         speed_arrival_pct;
  reg [15:0]        analog_fullscale_speed;
  reg signed [15:0] analog_zero_offset;
  reg [31:0]        rdData;
  reg               orientActive_q;

  wire              wrEn;
  wire [11:0]       wrAddr;
  wire [31:0]       wrData;
  wire [11:0]       rdAddr;
  wire [POS_W-1:0]  position;
  wire              referenced;
  wire [31:0]       countsRev32  = COUNTS_REV;
  wire [POS_W-1:0]  countsPerRev = countsRev32[POS_W-1:0];

  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [31:0] absVal;
    input signed [31:0] v;
    begin
      absVal = v[31] ? -v : v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  ahb_reg_slave u_bus (
    .clock     (clock),
    .nrst      (nrst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wrEn      (wrEn),
    .wrAddr    (wrAddr),
    .wrData    (wrData),
    .rdAddr    (rdAddr),
    .rdData    (rdData)
  );

  quad_position #(.POS_W(POS_W)) u_enc (
    .clock        (clock),
    .nrst         (nrst),
    .encA         (encA),
    .encB         (encB),
    .encZ         (encZ),
    .countsPerRev (countsPerRev),
    .position_q   (position),
    .referenced_q (referenced),
    .stepSum_q    ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, values clamped to their legal ranges
  always @(posedge clock) begin
    if (!nrst) begin
      ctrl_q                 <= `RST_CTRL;
      orient_speed_param     <= `RST_ORSPEED;
      orient_tolerance_param <= `RST_ORTOL;
      orient_target_one      <= {POS_W{1'b0}};
      orient_target_two      <= {POS_W{1'b0}};
      orient_target_three    <= {POS_W{1'b0}};
      orient_target_four     <= {POS_W{1'b0}};
      speed_arrival_pct      <= `RST_ARRPCT;
      analog_fullscale_speed <= `RST_FULLSCALE;
      analog_zero_offset     <= `RST_ZOFFSET;
    end else if (wrEn) begin
      case (wrAddr)
        `REG_CTRL:      ctrl_q <= {30'h0, wrData[1:0]};
        `REG_ORSPEED:   orient_speed_param <=
                          clamp16(wrData[15:0], `MIN_ORSPEED, `MAX_ORSPEED);
        `REG_ORTOL:     orient_tolerance_param <=
                          (wrData[7:0] > `MAX_ORTOL) ? `MAX_ORTOL : wrData[7:0];
        `REG_TGT1:      orient_target_one   <= wrData[POS_W-1:0];
        `REG_TGT2:      orient_target_two   <= wrData[POS_W-1:0];
        `REG_TGT3:      orient_target_three <= wrData[POS_W-1:0];
        `REG_TGT4:      orient_target_four  <= wrData[POS_W-1:0];
        `REG_ARRPCT:    speed_arrival_pct <= (wrData[7:0] < `MIN_ARRPCT) ? `MIN_ARRPCT :
                          ((wrData[7:0] > `MAX_ARRPCT) ? `MAX_ARRPCT : wrData[7:0]);
        `REG_FULLSCALE: analog_fullscale_speed <=
                          clamp16(wrData[15:0], 16'd0, `MAX_FULLSCALE);
        `REG_ZOFFSET: begin
          if ($signed(wrData[15:0]) < `MIN_ZOFFSET)
            analog_zero_offset <= -16'sd1000;
          else if ($signed(wrData[15:0]) > `MAX_ZOFFSET)
            analog_zero_offset <= 16'sd1000;
          else
            analog_zero_offset <= wrData[15:0];
        end
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  always @* begin
    case (rdAddr)
      `REG_CTRL:      rdData = ctrl_q;
      `REG_ORSPEED:   rdData = {16'h0, orient_speed_param};
      `REG_ORTOL:     rdData = {24'h0, orient_tolerance_param};
      `REG_TGT1:      rdData = {{(32-POS_W){1'b0}}, orient_target_one};
      `REG_TGT2:      rdData = {{(32-POS_W){1'b0}}, orient_target_two};
      `REG_TGT3:      rdData = {{(32-POS_W){1'b0}}, orient_target_three};
      `REG_TGT4:      rdData = {{(32-POS_W){1'b0}}, orient_target_four};
      `REG_ARRPCT:    rdData = {24'h0, speed_arrival_pct};
      `REG_FULLSCALE: rdData = {16'h0, analog_fullscale_speed};
      `REG_ZOFFSET:   rdData = {{16{analog_zero_offset[15]}}, analog_zero_offset};
      `REG_STATUS:    rdData = {27'h0, motorLock, posLoopEn, arrival_out,
                                orient_done_out, positionValid};
      `REG_POSITION:  rdData = {{(32-POS_W){1'b0}}, position};
      `REG_SPEED:     rdData = {{16{speedRef[15]}}, speedRef};
      default:        rdData = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target select; select inputs ignored unless enabled
  reg [POS_W-1:0] target;
  always @* begin
    if (!ctrl_q[`CTRL_SELEN_BIT]) begin
      target = orient_target_one;
    end else begin
      case (orient_select_in)
        2'b00:   target = orient_target_one;
        2'b01:   target = orient_target_two;
        2'b10:   target = orient_target_three;
        2'b11:   target = orient_target_four;
        default: target = orient_target_one;
      endcase
    end
  end

  // Shortest signed distance around one revolution
  reg signed [31:0] posErr;
  reg signed [31:0] rawErr;
  always @* begin
    rawErr = $signed({{(32-POS_W){1'b0}}, target}) - $signed({{(32-POS_W){1'b0}}, position});
    if (rawErr > $signed(COUNTS_REV / 2))
      posErr = rawErr - COUNTS_REV;
    else if (rawErr < -$signed(COUNTS_REV / 2))
      posErr = rawErr + COUNTS_REV;
    else
      posErr = rawErr;
  end

  wire [31:0] errMag   = absVal(posErr);
  wire        inWindow = errMag <= {24'h0, orient_tolerance_param};

  ////////////////////////////////////////////////////////////////////////////
  // Analog command scaling, offset and clamp
  reg signed [31:0] cmdSum;
  reg signed [47:0] cmdScaled;
  reg signed [15:0] cmdSpeed;
  always @* begin
    cmdSum    = $signed(analog_speed_cmd) + analog_zero_offset;
    cmdScaled = (cmdSum * $signed({1'b0, analog_fullscale_speed})) / `CMD_FULL_CODE;
    if (cmdScaled > 48'sd32767)
      cmdSpeed = 16'sh7fff;
    else if (cmdScaled < -48'sd32767)
      cmdSpeed = -16'sh7fff;
    else
      cmdSpeed = cmdScaled[15:0];
  end

  // Window around command, mirrored for negative commands
  wire [31:0] cmdMag = absVal({{16{cmdSpeed[15]}}, cmdSpeed});
  wire [31:0] actMag = absVal({{16{actualSpeed[15]}}, actualSpeed});
  wire [39:0] actScaled = actMag * 8'd100;
  wire [39:0] loBound   = cmdMag * (8'd100 - speed_arrival_pct);
  wire [39:0] hiBound   = cmdMag * (8'd100 + speed_arrival_pct);
  wire        sameSign  = (cmdSpeed[15] == actualSpeed[15]) || (actualSpeed == 16'sd0);
  wire        inArrival = sameSign && actScaled >= loBound && actScaled <= hiBound;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (!nrst) begin
      orientActive_q  <= 1'b0;
      orient_done_out <= 1'b0;
      arrival_out     <= 1'b0;
      posLoopEn       <= 1'b0;
      motorLock       <= 1'b0;
      speedRef        <= 16'sh0000;
      positionValid   <= 1'b0;
    end else begin
      positionValid  <= referenced;
      orientActive_q <= orient_request_in && servo_enable_in;
      if (orient_request_in && servo_enable_in) begin
        posLoopEn <= 1'b1;
        motorLock <= 1'b0;
        if (!referenced || !inWindow)
          speedRef <= $signed(orient_speed_param);
        else
          speedRef <= 16'sh0000;
        orient_done_out <= referenced && inWindow && orientActive_q;
      end else if (servo_enable_in && zero_clamp_in && ctrl_q[`CTRL_SPDMODE_BIT]) begin
        posLoopEn       <= 1'b1;
        motorLock       <= 1'b1;
        speedRef        <= 16'sh0000;
        orient_done_out <= 1'b0;
      end else begin
        posLoopEn       <= 1'b0;
        motorLock       <= 1'b0;
        orient_done_out <= 1'b0;
        speedRef        <= (servo_enable_in && forward_run_in) ? cmdSpeed : 16'sh0000;
      end
      arrival_out <= ctrl_q[`CTRL_SPDMODE_BIT] && servo_enable_in &&
                     !orient_request_in && inArrival;
    end
  end
endmodule // spindle_orientation_speed_arrival

/* verif/spindle_checker_properties.sv */
// Port assertions for the spindle orientation and speed arrival core
`timescale 1ns/1ps
module spindle_checker #(
  parameter CMD_W = 16
) (
  input wire logic                    clock,
  input wire logic                    nrst,
  input wire logic                    servo_enable_in,
  input wire logic                    orient_request_in,
  input wire logic                    zero_clamp_in,
  input wire logic signed [CMD_W-1:0] analog_speed_cmd,
  input wire logic signed [15:0]      actualSpeed,
  input wire logic                    orient_done_out,
  input wire logic                    arrival_out,
  input wire logic                    posLoopEn,
  input wire logic                    motorLock,
  input wire logic                    positionValid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  sequence reqHeld;
    (orient_request_in && servo_enable_in && positionValid) [*2];
  endsequence
  sequence clampHeld;
    (zero_clamp_in && servo_enable_in && !orient_request_in && analog_speed_cmd != 0) [*2];
  endsequence
  sequence zeroCmd;
    (analog_speed_cmd == 0 && actualSpeed != 0) [*3];
  endsequence
  ////////////////////////////////////////
  loop_on_request_a: assert property (reqHeld |-> ##[0:2] posLoopEn)
    else $error("position loop not enabled");
  done_after_request_a: assert property (orient_done_out |-> $past(orient_request_in))
    else $error("done without request");
  done_drop_a: assert property ($fell(orient_request_in) |-> ##1 !orient_done_out)
    else $error("done kept after release");
  done_needs_ref_a: assert property (orient_done_out |-> positionValid)
    else $error("done while unreferenced");
  valid_sticky_a: assert property (positionValid |=> positionValid)
    else $error("reference lost");
  lock_on_clamp_a: assert property (clampHeld |-> ##[0:2] motorLock)
    else $error("clamp did not lock");
  lock_needs_clamp_a: assert property (motorLock |-> $past(zero_clamp_in))
    else $error("lock without clamp");
  no_arrival_zero_a: assert property (zeroCmd |-> !arrival_out)
    else $error("arrival on zero command");
endmodule // spindle_checker

/* verif/cnc_partner.sv */
// Controller model driving the discrete spindle inputs
`timescale 1ns/1ps
module cnc_partner (
  input  wire logic  clock,
  input  wire logic  doneIn,
  output logic       servoEn,
  output logic       runFwd,
  output logic       orientReq,
  output logic [1:0] orientSel,
  output logic       clampReq
);
  initial begin
    {servoEn, runFwd, orientReq, clampReq, orientSel} = 6'h0;
  end
  task automatic enable(input logic on);
    @(posedge clock);
    servoEn <= on;
    runFwd <= on;
  endtask
  task automatic start(input logic [1:0] sel);
    orientSel <= sel;
    enable(1'b1);
    @(posedge clock);
    orientReq <= 1'b1;
  endtask
  task automatic waitDone(input int lim, output logic got);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clock);
      got = doneIn === 1'b1;
    end
  endtask
  // Tool change time, then release and drop drive
  task automatic stop(input int hold);
    repeat (hold) @(posedge clock);
    orientReq <= 1'b0;
    enable(1'b0);
  endtask
  task automatic clamp(input logic on);
    @(posedge clock);
    clampReq <= on;
  endtask
endmodule // cnc_partner

/* verif/test_spindle_orientation_speed_arrival.sv */
// Self-checking bench for the spindle orientation and speed arrival core
`timescale 1ns/1ps
`include "spindle_regs.vh"
module test_spindle_orientation_speed_arrival;
  logic               clock, nrst, hsel, hwrite, encA, encB, encZ, got;
  logic        [1:0]  htrans;
  logic        [2:0]  hsize;
  logic        [31:0] haddr, hwdata, rd;
  logic signed [15:0] cmd, actual;
  wire                hreadyout, hresp, done, arr, loopEn, lock, valid;
  wire                servoEn, runFwd, req, clamp;
  wire         [1:0]  sel;
  wire         [31:0] hrdata;
  wire signed  [15:0] speedRef;
  int mismatches, n_checks, cycles, seed, ph, p, lo, hi, sp;
  int pcts [3] = '{1, 10, 100};
  logic [11:0] rA [7] = '{`REG_CTRL, `REG_ORSPEED, `REG_ORTOL, `REG_ARRPCT, `REG_FULLSCALE,
                          `REG_ZOFFSET, 12'h100};
  logic [31:0] rV [7] = '{32'h2, 32'h64, 32'h2, 32'ha, 32'h1770, 32'h0, 32'h0};
  logic [11:0] wA [8] = '{`REG_ORSPEED, `REG_ORSPEED, `REG_ORTOL, `REG_ARRPCT, `REG_ARRPCT,
                          `REG_FULLSCALE, `REG_ZOFFSET, 12'h100};
  logic [31:0] wD [8] = '{32'h7d0, 32'h4, 32'hc8, 32'h0, 32'h65, 32'h4e20, 32'h3e8, 32'h5};
  logic [31:0] wE [8] = '{32'h3e8, 32'h5, 32'h64, 32'h1, 32'h64, 32'h3c8c, 32'h3e8, 32'h0};

  spindle_orientation_speed_arrival #(.COUNTS_REV(64)) dut (.clock(clock), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .servo_enable_in(servoEn), .forward_run_in(runFwd),
    .orient_request_in(req), .orient_select_in(sel), .zero_clamp_in(clamp),
    .analog_speed_cmd(cmd), .actualSpeed(actual), .encA(encA), .encB(encB), .encZ(encZ),
    .orient_done_out(done), .arrival_out(arr), .posLoopEn(loopEn), .motorLock(lock),
    .speedRef(speedRef), .positionValid(valid));
  cnc_partner pu (.clock(clock), .doneIn(done), .servoEn(servoEn), .runFwd(runFwd),
    .orientReq(req), .orientSel(sel), .clampReq(clamp));
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
    @(posedge clock);
  endtask
  // Optional index pulse, then n forward counts, B leading A
  task automatic step(input int n, input logic z);
    encZ <= z;
    repeat (4) @(posedge clock);
    encZ <= 1'b0;
    repeat (n) begin
      ph = (ph + 1) % 4;
      encA <= ph > 1;
      encB <= ph == 1 || ph == 2;
      repeat (4) @(posedge clock);
    end
  endtask
  task automatic arrive(input int a);
    actual <= 16'(a);
    repeat (3) @(posedge clock);
    check(arr, (a >= lo && a <= hi) || (a <= lo && a >= hi));
  endtask
  ////////////////////////////////////////
  initial begin
    {nrst, hsel, hwrite, encA, encB, encZ} = 6'h0;
    htrans = 2'b00;
    hsize = 3'b000;
    haddr = 32'h0;
    hwdata = 32'h0;
    cmd = 16'sh0;
    actual = 16'sh0;
    seed = 48081;
    ph = 0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    check({done, arr, loopEn, lock, valid, speedRef}, 21'h0);
    foreach (rA[i]) begin
      bus(1'b0, rA[i], 32'h0);
      check(rd, rV[i]);
    end
    foreach (wA[i]) begin
      bus(1'b1, wA[i], wD[i]);
      bus(1'b0, wA[i], 32'h0);
      check(rd, wE[i]);
    end
    foreach (rA[i]) bus(1'b1, rA[i], rV[i]);
    $display("test registers done");
    step(40, 1'b0);
    check(valid, 1'b0);
    step(8, 1'b1);
    check(valid, 1'b1);
    bus(1'b0, `REG_POSITION, 32'h0);
    check(rd, 32'h8);
    $display("test reference done");
    bus(1'b1, `REG_TGT1, 32'h8);
    pu.start(2'b11);
    pu.waitDone(20, got);
    check({got, loopEn}, 2'b11);
    pu.stop(10);
    repeat (2) @(posedge clock);
    check(done, 1'b0);
    bus(1'b1, `REG_CTRL, 32'h3);
    bus(1'b1, `REG_TGT2, 32'h1c);
    pu.start(2'b01);
    pu.waitDone(20, got);
    check({got, speedRef}, {1'b0, 16'sd100});
    step(17, 1'b0);
    check(done, 1'b0);
    step(1, 1'b0);
    check(done, 1'b1);
    pu.stop(0);
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 4; t++) bus(1'b1, 12'(`REG_TGT1 + 4 * t), t == s ? 32'h1c : 32'h30);
      pu.start(s[1:0]);
      pu.waitDone(20, got);
      check(got, 1'b1);
      pu.stop(2);
    end
    $display("test orientation done");
    pu.enable(1'b1);
    foreach (pcts[k]) begin
      p = pcts[k];
      bus(1'b1, `REG_ARRPCT, p);
      for (int g = -1; g < 2; g++) begin
        sp = 6000 * g;
        cmd <= 16'(32767 * g);
        repeat (3) @(posedge clock);
        check({16'h0, speedRef}, {16'h0, 16'(sp)});
        lo = sp * (100 - p) / 100;
        hi = sp * (100 + p) / 100;
        for (int d = -1; d < 2; d++) begin
          arrive(lo + d);
          arrive(hi + d);
        end
        repeat (3) arrive(sp + $random(seed) % 1500);
      end
    end
    $display("test arrival done");
    bus(1'b1, `REG_ZOFFSET, 32'hffff_f000);
    bus(1'b0, `REG_ZOFFSET, 32'h0);
    check(rd, 32'hffff_fc18);
    cmd <= 16'sd1000;
    repeat (3) @(posedge clock);
    check({16'h0, speedRef}, 32'h0);
    cmd <= 16'sd16000;
    pu.clamp(1'b1);
    repeat (3) @(posedge clock);
    check(lock, 1'b1);
    pu.clamp(1'b0);
    repeat (3) @(posedge clock);
    check(lock, 1'b0);
    $display("test clamp done");
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    check({valid, lock, done}, 3'h0);
    bus(1'b0, `REG_CTRL, 32'h0);
    check(rd, 32'h2);
    $display("test reset done");
    end_of_test();
  end
endmodule // test_spindle_orientation_speed_arrival

bind spindle_orientation_speed_arrival spindle_checker #(.CMD_W(CMD_W)) chk (.clock(clock),
  .nrst(nrst), .servo_enable_in(servo_enable_in), .orient_request_in(orient_request_in),
  .zero_clamp_in(zero_clamp_in), .analog_speed_cmd(analog_speed_cmd),
  .actualSpeed(actualSpeed), .orient_done_out(orient_done_out), .arrival_out(arrival_out),
  .posLoopEn(posLoopEn), .motorLock(motorLock), .positionValid(positionValid));
